// ===== design/etp_pkg.sv
package etp_pkg;

    // Register indices; byte address is four times the index
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] IDX_TIMER_COUNT = 12'h001;
    localparam logic [ADDR_W-1:0] IDX_INTERRUPT_CONTROL = 12'h00B;
    localparam logic [ADDR_W-1:0] IDX_OPTION_CONTROL = 12'h081;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h090;
    localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR = 12'h091;
    localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE = 12'h092;
    localparam logic [ADDR_W-1:0] IDX_WDT_CONTROL = 12'h093;
    localparam logic [ADDR_W-1:0] IDX_WDT_COUNT = 12'h094;

    localparam logic [ADDR_W-1:0] ADDR_TIMER_COUNT = ADDR_W'(IDX_TIMER_COUNT << 2);
    localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_CONTROL = ADDR_W'(IDX_INTERRUPT_CONTROL << 2);
    localparam logic [ADDR_W-1:0] ADDR_OPTION_CONTROL = ADDR_W'(IDX_OPTION_CONTROL << 2);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = ADDR_W'(IDX_IRQ_STATUS << 2);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = ADDR_W'(IDX_IRQ_CLEAR << 2);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = ADDR_W'(IDX_IRQ_ENABLE << 2);
    localparam logic [ADDR_W-1:0] ADDR_WDT_CONTROL = ADDR_W'(IDX_WDT_CONTROL << 2);
    localparam logic [ADDR_W-1:0] ADDR_WDT_COUNT = ADDR_W'(IDX_WDT_COUNT << 2);

    // Field positions
    localparam int ICTL_GLOBAL_EN = 7;
    localparam int ICTL_PERIPH_EN = 6;
    localparam int ICTL_TIMER_EN = 5;
    localparam int ICTL_TIMER_FLAG = 2;
    localparam int IRQ_TIMER = 0;
    localparam int IRQ_WDT = 1;
    localparam int IRQ_W = 2;
    localparam int WCTL_ENABLE = 0;
    localparam int WCTL_CLEAR = 1;

    // Reset values
    localparam logic [7:0] TIMER_COUNT_RST = 8'h00;
    localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
    localparam logic [7:0] OPTION_CONTROL_RST = 8'hFF;
    localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 2'h0;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing counts in core clock cycles; watchdog width in bits
    localparam int INSTR_DIV_DEF = 4;
    localparam int WDT_BASE_DIV_DEF = 64;
    localparam int WDT_BITS_DEF = 8;

    typedef struct packed {
        logic pullupDisable;
        logic intEdge;
        logic countSourceSelect;
        logic countEdgeSelect;
        logic prescalerAssign;
        logic [2:0] prescaleRate;
    } etp_option_t;

endpackage : etp_pkg

// ===== design/etp_sync_edge.sv
`timescale 1ns/1ps

// Two-flop synchroniser with edge pulses
module etp_sync_edge import etp_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Asynchronous pin
    input wire logic pinIn,
    // Edge pulses
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } etp_sync_t;

    etp_sync_t st_ff;
    etp_sync_t nxt_st;

    always_comb begin
        nxt_st.s1 = pinIn;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rise = st_ff.s2 & ~st_ff.s3;
    assign fall = ~st_ff.s2 & st_ff.s3;

endmodule : etp_sync_edge

// ===== design/etp_prescaler.sv
`timescale 1ns/1ps

// Ripple-free prescaler: passes one tick out of 2**shift
module etp_prescaler import etp_pkg::*; #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic tickIn,
    input wire logic clear,
    input wire logic [3:0] shift,
    // Output
    output logic tickOut
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } etp_presc_t;

    etp_presc_t st_ff;
    etp_presc_t nxt_st;
    logic [CNT_W:0] fullMask;
    logic [CNT_W-1:0] mask;

    always_comb begin
        fullMask = (CNT_W+1)'(({{CNT_W{1'b0}}, 1'b1} << shift) - 1'b1);
        mask = fullMask[CNT_W-1:0];
        tickOut = tickIn & ~clear & ((st_ff.cnt & mask) == mask);
        nxt_st = st_ff;
        if (clear) begin
            nxt_st.cnt = '0;
        end else if (tickIn) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : etp_prescaler

// ===== design/etp_timer.sv
// Operation
// - Edge select 0: count external rising edges
// - Assign bit 1: prescaler feeds watchdog
// - Assign bit 0: prescaler before timer
// - Timer ratio two to rate plus one
// - Watchdog clear clears watchdog and prescaler
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps

module etp_timer import etp_pkg::*; #(
    parameter int INSTR_DIV = INSTR_DIV_DEF,
    parameter int WDT_BASE_DIV = WDT_BASE_DIV_DEF,
    parameter int WDT_BITS = WDT_BITS_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // AXI4-Lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // External count input
    input wire logic externalCountPin,
    // Interrupts and watchdog
    output logic irq,
    output logic timerIrq,
    output logic watchdogReset
);

    typedef struct packed {
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic [ADDR_W-1:0] awAddr;
        logic [7:0] wData;
        logic wLane0;
        logic arReady;
        logic rValid;
        logic [1:0] rResp;
        logic [7:0] rData;
        logic [7:0] timerCount;
        logic [7:0] intCtl;
        etp_option_t option;
        logic [IRQ_W-1:0] irqStatus;
        logic [IRQ_W-1:0] irqEnable;
        logic wdtEnable;
        logic [WDT_BITS-1:0] wdtCount;
        logic [15:0] instrCnt;
        logic [15:0] wdtBaseCnt;
        logic irq;
        logic timerIrq;
        logic wdtReset;
    } etp_state_t;

    etp_state_t st_ff;
    etp_state_t nxt_st;

    logic extRise;
    logic extFall;
    logic instrTick;
    logic wdtBaseTick;
    logic srcTick;
    logic prescIn;
    logic prescOut;
    logic prescClear;
    logic [3:0] prescShift;
    logic timerTick;
    logic wdtTick;
    logic doWrite;
    logic wrEn;
    logic wrTimer;
    logic wrIntCtl;
    logic wrOption;
    logic wrIrqClear;
    logic wrIrqEnable;
    logic wrWdtCtl;
    logic wdtClear;
    logic wrHit;
    logic timerOverflow;
    logic wdtTimeout;
    logic [IRQ_W-1:0] irqEvents;
    logic [IRQ_W-1:0] irqClearBits;
    logic rdHit;
    logic [7:0] rdValue;

    etp_sync_edge u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pinIn(externalCountPin),
        .rise(extRise),
        .fall(extFall)
    );

    etp_prescaler #(
        .CNT_W(8)
    ) u_presc (
        .core_clk(core_clk),
        .reset(reset),
        .tickIn(prescIn),
        .clear(prescClear),
        .shift(prescShift),
        .tickOut(prescOut)
    );

    always_comb begin
        nxt_st = st_ff;

        // Base ticks
        instrTick = (st_ff.instrCnt == 16'(INSTR_DIV - 1));
        wdtBaseTick = (st_ff.wdtBaseCnt == 16'(WDT_BASE_DIV - 1));
        nxt_st.instrCnt = instrTick ? 16'h0000 : st_ff.instrCnt + 16'h0001;
        nxt_st.wdtBaseCnt = wdtBaseTick ? 16'h0000 : st_ff.wdtBaseCnt + 16'h0001;

        // Count source and edge
        // Pin edges arrive two cycles after the pin moves
        if (st_ff.option.countSourceSelect) begin
            srcTick = st_ff.option.countEdgeSelect ? extFall : extRise;
        end else begin
            srcTick = instrTick;
        end

        // Prescaler routing
        // Reassignment keeps the count; software clears it first
        if (st_ff.option.prescalerAssign) begin
            prescIn = wdtBaseTick;
            prescShift = {1'b0, st_ff.option.prescaleRate};
            timerTick = srcTick;
            wdtTick = prescOut;
        end else begin
            prescIn = srcTick;
            prescShift = {1'b0, st_ff.option.prescaleRate} + 4'h1;
            timerTick = prescOut;
            wdtTick = wdtBaseTick;
        end

        // Write decode
        // The write lands the cycle after both channels are in
        doWrite = ~st_ff.awReady & ~st_ff.wReady & ~st_ff.bValid;
        wrEn = doWrite & st_ff.wLane0;
        wrTimer = wrEn & (st_ff.awAddr == ADDR_TIMER_COUNT);
        wrIntCtl = wrEn & (st_ff.awAddr == ADDR_INTERRUPT_CONTROL);
        wrOption = wrEn & (st_ff.awAddr == ADDR_OPTION_CONTROL);
        wrIrqClear = wrEn & (st_ff.awAddr == ADDR_IRQ_CLEAR);
        wrIrqEnable = wrEn & (st_ff.awAddr == ADDR_IRQ_ENABLE);
        wrWdtCtl = wrEn & (st_ff.awAddr == ADDR_WDT_CONTROL);
        wdtClear = wrWdtCtl & st_ff.wData[WCTL_CLEAR];
        wrHit = (st_ff.awAddr == ADDR_TIMER_COUNT)
            | (st_ff.awAddr == ADDR_INTERRUPT_CONTROL)
            | (st_ff.awAddr == ADDR_OPTION_CONTROL)
            | (st_ff.awAddr == ADDR_IRQ_STATUS)
            | (st_ff.awAddr == ADDR_IRQ_CLEAR)
            | (st_ff.awAddr == ADDR_IRQ_ENABLE)
            | (st_ff.awAddr == ADDR_WDT_CONTROL)
            | (st_ff.awAddr == ADDR_WDT_COUNT);

        // Timer writes also restart a timer-side prescaler
        prescClear = wdtClear | (wrTimer & ~st_ff.option.prescalerAssign);

        // Eight-bit counter
        timerOverflow = timerTick & ~wrTimer & (st_ff.timerCount == 8'hFF);
        if (wrTimer) begin
            nxt_st.timerCount = st_ff.wData;
        end else if (timerTick) begin
            nxt_st.timerCount = st_ff.timerCount + 8'h01;
        end

        // Watchdog
        // A clear in the timeout cycle wins
        wdtTimeout = st_ff.wdtEnable & wdtTick & ~wdtClear & (&st_ff.wdtCount);
        if (wdtClear) begin
            nxt_st.wdtCount = '0;
        end else if (st_ff.wdtEnable & wdtTick) begin
            nxt_st.wdtCount = st_ff.wdtCount + 1'b1;
        end
        if (wrWdtCtl) begin
            nxt_st.wdtEnable = st_ff.wData[WCTL_ENABLE];
        end
        nxt_st.wdtReset = wdtTimeout;

        // Control registers
        // Hardware setting the flag wins over a software clear
        if (wrOption) begin
            nxt_st.option = st_ff.wData;
        end
        if (wrIntCtl) begin
            nxt_st.intCtl = st_ff.wData;
        end
        if (timerOverflow) begin
            nxt_st.intCtl[ICTL_TIMER_FLAG] = 1'b1;
        end
        // Next state so the level moves on the same edge as the flag
        nxt_st.timerIrq = nxt_st.intCtl[ICTL_GLOBAL_EN] & nxt_st.intCtl[ICTL_TIMER_EN]
            & nxt_st.intCtl[ICTL_TIMER_FLAG];

        // Sticky status, set wins over clear
        irqEvents = '0;
        irqEvents[IRQ_TIMER] = timerOverflow;
        irqEvents[IRQ_WDT] = wdtTimeout;
        irqClearBits = wrIrqClear ? st_ff.wData[IRQ_W-1:0] : '0;
        nxt_st.irqStatus = (st_ff.irqStatus & ~irqClearBits) | irqEvents;
        if (wrIrqEnable) begin
            nxt_st.irqEnable = st_ff.wData[IRQ_W-1:0];
        end
        nxt_st.irq = |(nxt_st.irqStatus & nxt_st.irqEnable);

        // Write channels
        if (st_ff.awReady & s_axi_awvalid) begin
            nxt_st.awReady = 1'b0;
            nxt_st.awAddr = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
        end
        if (st_ff.wReady & s_axi_wvalid) begin
            nxt_st.wReady = 1'b0;
            nxt_st.wData = s_axi_wdata[7:0];
            nxt_st.wLane0 = s_axi_wstrb[0];
        end
        if (doWrite) begin
            nxt_st.bValid = 1'b1;
            nxt_st.bResp = wrHit ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_ff.bValid & s_axi_bready) begin
            nxt_st.bValid = 1'b0;
            nxt_st.awReady = 1'b1;
            nxt_st.wReady = 1'b1;
        end

        // Read channel
        // Data is captured at the edge that takes the address
        rdHit = 1'b1;
        unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
            ADDR_TIMER_COUNT: rdValue = st_ff.timerCount;
            ADDR_INTERRUPT_CONTROL: rdValue = st_ff.intCtl;
            ADDR_OPTION_CONTROL: rdValue = st_ff.option;
            ADDR_IRQ_STATUS: rdValue = 8'(st_ff.irqStatus);
            ADDR_IRQ_CLEAR: rdValue = 8'h00;
            ADDR_IRQ_ENABLE: rdValue = 8'(st_ff.irqEnable);
            ADDR_WDT_CONTROL: rdValue = {7'h00, st_ff.wdtEnable};
            ADDR_WDT_COUNT: rdValue = 8'(st_ff.wdtCount);
            default: begin
                rdValue = 8'h00;
                rdHit = 1'b0;
            end
        endcase
        if (st_ff.arReady & s_axi_arvalid) begin
            nxt_st.arReady = 1'b0;
            nxt_st.rValid = 1'b1;
            nxt_st.rData = rdValue;
            nxt_st.rResp = rdHit ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_ff.rValid & s_axi_rready) begin
            nxt_st.rValid = 1'b0;
            nxt_st.arReady = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.awReady <= 1'b1;
            st_ff.wReady <= 1'b1;
            st_ff.arReady <= 1'b1;
            st_ff.timerCount <= TIMER_COUNT_RST;
            st_ff.intCtl <= INTERRUPT_CONTROL_RST;
            st_ff.option <= OPTION_CONTROL_RST;
            st_ff.irqEnable <= IRQ_ENABLE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awReady;
    assign s_axi_wready = st_ff.wReady;
    assign s_axi_bvalid = st_ff.bValid;
    assign s_axi_bresp = st_ff.bResp;
    assign s_axi_arready = st_ff.arReady;
    assign s_axi_rvalid = st_ff.rValid;
    assign s_axi_rdata = {24'h00_0000, st_ff.rData};
    assign s_axi_rresp = st_ff.rResp;
    assign irq = st_ff.irq;
    assign timerIrq = st_ff.timerIrq;
    assign watchdogReset = st_ff.wdtReset;

endmodule : etp_timer

// ===== tb/etp_timer_assertions.sv
`timescale 1ns/1ps

module etp_timer_assertions import etp_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // Read channels
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Outputs
    input wire logic irq,
    input wire logic timerIrq,
    input wire logic watchdogReset
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
    a_write_release: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not released");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> !s_axi_arready && s_axi_rvalid) else $error("read answer late");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready) else $error("read not released");
    a_rdata_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read lanes not zero");
    a_bresp_legal: assert property (s_axi_bvalid
        |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR) else $error("bad bresp");
    a_wdog_pulse: assert property (watchdogReset |=> !watchdogReset)
        else $error("watchdog pulse too long");
    a_reset_quiet: assert property (disable iff (1'b0) reset
        |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !timerIrq && !watchdogReset)
        else $error("outputs active in reset");
    a_timer_irq_hold: assert property ($fell(timerIrq)
        |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("timer irq dropped alone");
    a_irq_hold: assert property ($fell(irq)
        |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq dropped alone");

    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    cover property ($rose(irq));
    cover property ($fell(timerIrq));
    cover property (watchdogReset);
endmodule : etp_timer_assertions

bind etp_timer etp_timer_assertions u_chk (
    .core_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .irq, .timerIrq, .watchdogReset
);

// ===== tb/tb_top.sv
`timescale 1ns/1ps

`define CHK(nm, got, exp) begin checksDone++; if ((got) !== (exp)) begin failCount++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

module tb_top import etp_pkg::*; ();
    localparam int WB = 3;
    localparam int WD = 2;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic [ADDR_W-1:0] awAddr = '0, arAddr = '0;
    logic [31:0] wData = '0, rData, gotData;
    logic [3:0] wStrb = '0;
    logic [1:0] bResp, rResp, gotResp;
    logic awReady, wReady, bValid, arReady, rValid, irq, timerIrq, wdReset, pinLvl = 1'b0;
    int failCount = 0, checksDone = 0, n;

    etp_timer #(.INSTR_DIV(2), .WDT_BASE_DIV(WD), .WDT_BITS(WB)) dut (
        .core_clk(core_clk), .reset(reset),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .externalCountPin(pinLvl), .irq(irq), .timerIrq(timerIrq), .watchdogReset(wdReset)
    );

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : reportAndStop

    task automatic axWrite(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
        awValid <= 1'b1;
        awAddr <= a;
        wValid <= 1'b1;
        wData <= {24'h00_0000, d};
        wStrb <= s;
        bReady <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid && bReady) break;
        end
        gotResp = bResp;
        bReady <= 1'b0;
        @(posedge core_clk);
    endtask : axWrite

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        axWrite(a, d, 4'h1);
    endtask : wr

    task automatic axRead(input logic [ADDR_W-1:0] a);
        arValid <= 1'b1;
        arAddr <= a;
        rReady <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid && rReady) break;
        end
        gotData = rData;
        gotResp = rResp;
        rReady <= 1'b0;
        @(posedge core_clk);
    endtask : axRead

    task automatic chkRd(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        axRead(a);
        `CHK(nm, gotData, e)
    endtask : chkRd

    // Pin pulses, then room for the synchroniser
    task automatic pulses(input int cnt);
        repeat (cnt) begin
            pinLvl <= 1'b1;
            repeat (4) @(posedge core_clk);
            pinLvl <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
        repeat (6) @(posedge core_clk);
    endtask : pulses

    // Cycles from a watchdog clear to its timeout pulse
    task automatic wdTime(input logic [7:0] opt, input int exp);
        wr(ADDR_WDT_CONTROL, 8'h02);
        wr(ADDR_OPTION_CONTROL, opt);
        wr(ADDR_WDT_CONTROL, 8'h03);
        n = 0;
        while (!wdReset && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        `CHK("wdSpan", (n >= exp - 4 && n <= exp + 4), 1'b1)
        wr(ADDR_WDT_CONTROL, 8'h00);
    endtask : wdTime

    initial begin
        repeat (60000) @(posedge core_clk);
        failCount++;
        reportAndStop();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chkRd("optRst", ADDR_OPTION_CONTROL, 32'h0000_00FF);
        `CHK("rdResp", gotResp, RESP_OKAY)
        chkRd("cntRst", ADDR_TIMER_COUNT, 32'h0000_0000);
        chkRd("ictlRst", ADDR_INTERRUPT_CONTROL, 32'h0000_0000);
        chkRd("ienRst", ADDR_IRQ_ENABLE, 32'h0000_0000);
        chkRd("statRst", ADDR_IRQ_STATUS, 32'h0000_0000);
        chkRd("wdCntRst", ADDR_WDT_COUNT, 32'h0000_0000);
        chkRd("badRd", 12'h3F0, 32'h0000_0000);
        `CHK("badRdResp", gotResp, RESP_SLVERR)
        axWrite(12'h3F0, 8'h55, 4'h1);
        `CHK("badWrResp", gotResp, RESP_SLVERR)
        axWrite(ADDR_OPTION_CONTROL, 8'h00, 4'h0);
        chkRd("noStrb", ADDR_OPTION_CONTROL, 32'h0000_00FF);
        $display("test bus done");
        wr(ADDR_OPTION_CONTROL, 8'h28);
        `CHK("wrResp", gotResp, RESP_OKAY)
        wr(ADDR_TIMER_COUNT, 8'h00);
        pulses(5);
        pinLvl <= 1'b1;
        repeat (6) @(posedge core_clk);
        chkRd("riseCnt", ADDR_TIMER_COUNT, 32'h0000_0006);
        wr(ADDR_OPTION_CONTROL, 8'h38);
        wr(ADDR_TIMER_COUNT, 8'h00);
        pulses(5);
        chkRd("fallCnt", ADDR_TIMER_COUNT, 32'h0000_0005);
        wr(ADDR_OPTION_CONTROL, 8'h08);
        wr(ADDR_TIMER_COUNT, 8'h00);
        repeat (40) @(posedge core_clk);
        axRead(ADDR_TIMER_COUNT);
        `CHK("instrCnt", (gotData >= 32'h0000_0010 && gotData <= 32'h0000_001A), 1'b1)
        $display("test edges done");
        wr(ADDR_WDT_CONTROL, 8'h02);
        for (int r = 0; r < 8; r++) begin
            wr(ADDR_OPTION_CONTROL, 8'h20 | 8'(r));
            wr(ADDR_TIMER_COUNT, 8'h00);
            pulses(3 << (r + 1));
            chkRd("rateCnt", ADDR_TIMER_COUNT, 32'h0000_0003);
        end
        $display("test rates done");
        wr(ADDR_OPTION_CONTROL, 8'h28);
        wr(ADDR_INTERRUPT_CONTROL, 8'h20);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_TIMER_COUNT, 8'hFE);
        pulses(2);
        chkRd("wrapCnt", ADDR_TIMER_COUNT, 32'h0000_0000);
        chkRd("flagSet", ADDR_INTERRUPT_CONTROL, 32'h0000_0024);
        `CHK("timerIrqGated", timerIrq, 1'b0)
        `CHK("irqOn", irq, 1'b1)
        wr(ADDR_INTERRUPT_CONTROL, 8'hA4);
        `CHK("timerIrqOn", timerIrq, 1'b1)
        wr(ADDR_IRQ_ENABLE, 8'h00);
        `CHK("irqMasked", irq, 1'b0)
        wr(ADDR_IRQ_ENABLE, 8'h01);
        `CHK("irqBack", irq, 1'b1)
        wr(ADDR_IRQ_CLEAR, 8'h01);
        `CHK("irqCleared", irq, 1'b0)
        chkRd("statClr", ADDR_IRQ_STATUS, 32'h0000_0000);
        wr(ADDR_INTERRUPT_CONTROL, 8'hA0);
        `CHK("timerIrqOff", timerIrq, 1'b0)
        $display("test irq done");
        wdTime(8'h08, (1 << WB) * WD);
        wdTime(8'h0A, (4 << WB) * WD);
        wdTime(8'h03, (1 << WB) * WD);
        wr(ADDR_WDT_CONTROL, 8'h01);
        repeat (40) @(posedge core_clk);
        wr(ADDR_WDT_CONTROL, 8'h02);
        chkRd("wdClr", ADDR_WDT_COUNT, 32'h0000_0000);
        wdTime(8'h0A, (4 << WB) * WD);
        axRead(ADDR_IRQ_STATUS);
        `CHK("wdStat", gotData[1], 1'b1)
        $display("test watchdog done");
        reportAndStop();
    end
endmodule : tb_top
